/* rtl/pwm_timer_map.svh */
`ifndef PWM_TIMER_MAP_SVH
`define PWM_TIMER_MAP_SVH
// register byte offsets
`define OFS_START        8'h00
`define OFS_PWM_MODE     8'h04
`define OFS_PWM_COUNT    8'h08
`define OFS_STATUS       8'h0C
`define OFS_TMR_MODE0    8'h10
`define OFS_TMR_COUNT0   8'h20
// start register fields
`define START_PWM_BIT    0
`define START_TMR_LSB    1
// pwm mode register fields
`define PM_MODE_LSB      0
`define PM_EIGHT_BIT     2
`define PM_CLK_LSB       3
`define PM_TRIG_LSB      5
// simple timer mode fields
`define TM_MODE_LSB      0
`define TM_CLK_LSB       2
// status fields
`define ST_PULSE_BIT     0
`define ST_RUN_BIT       1
`define ST_ARMED_BIT     2
`define ST_TRIG_PIN_BIT  3
// mode codes
`define MODE_PWM         2'h3
`define MODE_TIMER       2'h0
// clock select codes
`define CLK_F1           2'h0
`define CLK_F8           2'h1
// trigger select codes
`define TRIG_NONE        2'h0
`define TRIG_PIN         2'h1
`define TRIG_TMR0        2'h2
// period lengths minus one, in units
`define PERIOD16_LAST    16'hFFFE
`define PERIOD8_LAST     16'h00FE
// reset values and read answers
`define RST_COUNT        16'h0000
`define RST_MODE         8'h00
`define PWM_COUNT_READ   32'h0000_0000
`define UNMAPPED_READ    32'h0000_0000
`endif

/* rtl/pwm_timer_pkg.sv */
package pwm_timer_pkg;
  typedef enum logic [2:0] {
    PWM_IDLE  = 3'b001,
    PWM_ARMED = 3'b010,
    PWM_RUN   = 3'b100
  } pwm_state_e;
  typedef logic [1:0]  clk_sel_t;
  typedef logic [15:0] count_t;
  typedef logic [7:0]  wb_adr_t;
  typedef logic [31:0] wb_dat_t;
endpackage : pwm_timer_pkg

/* rtl/pwm_timer.sv */
// What this block does
// - pwm counter works as 16-bit or 8-bit modulator, counting down
// - count clock chosen from undivided, divide-by-8 or divide-by-32 clock
// - pwm counter reloads at each pulse rising edge and keeps counting
// - trigger events while counting neither restart nor reload the counter
// - 16-bit high time is n count clock periods
// - 16-bit period is fixed at 65535 count clock periods
// - 8-bit high time is n*(m+1) periods, n from upper byte
// - 8-bit period is 255*(m+1) periods, m from lower byte
// - pwm starts on pin trigger, trigger timer overflow or start flag
// - pwm stops only when software clears its start flag
// - pwm interrupt request each time the pulse falls low
// - trigger pin is general input or trigger; output pin carries pulse
// - reading the pwm count register returns no live count
// - pwm write loads reload and counter when stopped, reload only when running
// - simple timer mode bits 0 and 1 select mode; only timer mode exists
// - simple timer counts down, reloads on underflow, divides by n+1
// - simple timer runs while start flag is 1, halts when cleared
// - reading a simple timer count register returns its current count
// - simple timer write loads both when stopped, reload only when running
// - simple timers interrupt on underflow except the third, a prescaler only
// - channel has four modes; only pulse-width modulation is built here
`timescale 1ns/1ps
`include "pwm_timer_map.svh"
module pwm_timer (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire pwm_timer_pkg::wb_adr_t wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire pwm_timer_pkg::wb_dat_t wb_dat_i,
  output logic                        wb_ack_o,
  output pwm_timer_pkg::wb_dat_t      wb_dat_o,
  input  wire logic                   pwm_trigger_pin_i,
  output logic                        pwm_pulse_pin_o,
  output logic                        pwm_irq_o,
  output logic [1:0]                  timer_irq_o
);
  import pwm_timer_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // pick the count tick for a clock select code
  function automatic logic pick_tick(clk_sel_t sel, logic t1, logic t8, logic t32);
    unique case (sel)
      `CLK_F1: pick_tick = t1;
      `CLK_F8: pick_tick = t8;
      default: pick_tick = t32;
    endcase
  endfunction : pick_tick

  // merge the two low byte lanes of a write into a 16-bit value
  function automatic count_t merge16(count_t old, wb_dat_t d, logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [4:0]   pre_div;
  logic         tick8;
  logic         tick32;
  logic         req;
  logic         wr;
  logic [2:0]   tmr_start;
  logic         pwm_start;
  logic [7:0]   pwm_mode;
  logic [3:0]   tmr_mode [3];
  count_t       tmr_cnt [3];
  count_t       tmr_reload [3];
  logic [2:0]   tmr_tick;
  logic [2:0]   tmr_under;
  logic [2:0]   tmr_run;
  logic         trig_q;
  logic         trig_evt;
  pwm_state_e   state;
  pwm_state_e   next_state;
  count_t       pwm_reload;
  count_t       hi_cnt;
  count_t       per_cnt;
  logic [7:0]   pre_cnt;
  logic [7:0]   cur_m;
  logic         pwm_tick;
  logic         unit_tick;
  logic         begin_period;
  logic         next_pulse;
  logic         eight_bit;
  logic         pwm_run;
  logic         wr_pwm;
  count_t       new_hi;
  count_t       period_last;

  //////////////////////////////////////////////////////////////////////////////
  // count clock prescaler

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_div <= 5'h00;
    end else begin
      pre_div <= pre_div + 5'h01;
    end
  end
  assign tick8  = (pre_div[2:0] == 3'h7);
  assign tick32 = (pre_div == 5'h1F);

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave

  assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr     = req & wb_we_i;
  assign wr_pwm = wr & (wb_adr_i == `OFS_PWM_COUNT);

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // read data mux, registered with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= `UNMAPPED_READ;
    end else if (req & ~wb_we_i) begin
      wb_dat_o <= `UNMAPPED_READ;
      unique case (wb_adr_i)
        `OFS_START:     wb_dat_o <= {28'h0000000, tmr_start, pwm_start};
        `OFS_PWM_MODE:  wb_dat_o <= {24'h000000, pwm_mode};
        `OFS_PWM_COUNT: wb_dat_o <= `PWM_COUNT_READ;
        `OFS_STATUS:    wb_dat_o <= {28'h0000000, pwm_trigger_pin_i,
                                     state == PWM_ARMED, pwm_run, pwm_pulse_pin_o};
        default: begin
          for (int i = 0; i < 3; i++) begin
            if (wb_adr_i == `OFS_TMR_MODE0 + 8'(4 * i)) begin
              wb_dat_o <= {28'h0000000, tmr_mode[i]};
            end
            if (wb_adr_i == `OFS_TMR_COUNT0 + 8'(4 * i)) begin
              wb_dat_o <= {16'h0000, tmr_cnt[i]};
            end
          end
        end
      endcase
    end
  end

  // control registers: start flags and modes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_start <= 1'b0;
      tmr_start <= 3'h0;
      pwm_mode  <= `RST_MODE;
      for (int i = 0; i < 3; i++) begin
        tmr_mode[i] <= 4'h0;
      end
    end else if (wr & wb_sel_i[0]) begin
      if (wb_adr_i == `OFS_START) begin
        pwm_start <= wb_dat_i[`START_PWM_BIT];
        tmr_start <= wb_dat_i[`START_TMR_LSB +: 3];
      end
      if (wb_adr_i == `OFS_PWM_MODE) begin
        pwm_mode <= wb_dat_i[7:0];
      end
      for (int i = 0; i < 3; i++) begin
        if (wb_adr_i == `OFS_TMR_MODE0 + 8'(4 * i)) begin
          tmr_mode[i] <= wb_dat_i[3:0];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // simple reload timers

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      tmr_run[i]   = tmr_start[i] & (tmr_mode[i][`TM_MODE_LSB +: 2] == `MODE_TIMER);
      tmr_tick[i]  = tmr_run[i] & pick_tick(tmr_mode[i][`TM_CLK_LSB +: 2], 1'b1,
                                            tick8, tick32);
      tmr_under[i] = tmr_tick[i] & (tmr_cnt[i] == 16'h0000);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 3; i++) begin
        tmr_cnt[i]    <= `RST_COUNT;
        tmr_reload[i] <= `RST_COUNT;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (tmr_under[i]) begin
          tmr_cnt[i] <= tmr_reload[i];
        end else if (tmr_tick[i]) begin
          tmr_cnt[i] <= tmr_cnt[i] - 16'h0001;
        end
        if (wr & (wb_adr_i == `OFS_TMR_COUNT0 + 8'(4 * i))) begin
          tmr_reload[i] <= merge16(tmr_reload[i], wb_dat_i, wb_sel_i);
          if (!tmr_run[i]) begin
            tmr_cnt[i] <= merge16(tmr_reload[i], wb_dat_i, wb_sel_i);
          end
        end
      end
    end
  end

  // third timer is a prescaler only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_irq_o <= 2'h0;
    end else begin
      timer_irq_o <= tmr_under[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pwm start control

  // trigger pin edge, pin otherwise readable in status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= pwm_trigger_pin_i;
    end
  end

  // pin is a trigger only when selected
  always_comb begin
    unique case (pwm_mode[`PM_TRIG_LSB +: 2])
      `TRIG_PIN:  trig_evt = pwm_trigger_pin_i & ~trig_q;
      `TRIG_TMR0: trig_evt = tmr_under[0];
      `TRIG_NONE: trig_evt = 1'b0;
      default:    trig_evt = tmr_under[1];
    endcase
  end

  // start on flag, pin or timer overflow
  always_comb begin
    next_state = state;
    unique case (state)
      PWM_IDLE: begin
        // other channel modes leave it idle
        if (pwm_start && pwm_mode[`PM_MODE_LSB +: 2] == `MODE_PWM) begin
          next_state = (pwm_mode[`PM_TRIG_LSB +: 2] == `TRIG_NONE) ? PWM_RUN : PWM_ARMED;
        end
      end
      PWM_ARMED: begin
        if (!pwm_start) begin
          next_state = PWM_IDLE;
        end else if (trig_evt) begin
          next_state = PWM_RUN;
        end
      end
      PWM_RUN: begin
        // only a cleared flag stops it
        if (!pwm_start) begin
          next_state = PWM_IDLE;
        end
      end
      default: next_state = PWM_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= PWM_IDLE;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pwm engine

  assign pwm_run   = (state == PWM_RUN);
  assign eight_bit = pwm_mode[`PM_EIGHT_BIT];
  // pwm uses the same tick choice
  assign pwm_tick  = pwm_run & pick_tick(pwm_mode[`PM_CLK_LSB +: 2], 1'b1, tick8, tick32);
  // unit is m+1 ticks in 8-bit form
  assign unit_tick = pwm_tick & (~eight_bit | (pre_cnt == 8'h00));
  // a trigger while running cannot start a period
  assign begin_period = (next_state == PWM_RUN) & ~pwm_run;
  assign period_last = eight_bit ? `PERIOD8_LAST : `PERIOD16_LAST;
  assign new_hi = eight_bit ? {8'h00, pwm_reload[15:8]} : pwm_reload;

  // next pulse level
  always_comb begin
    next_pulse = pwm_pulse_pin_o;
    if (next_state != PWM_RUN) begin
      next_pulse = 1'b0;
    end else if (begin_period || (unit_tick && per_cnt == 16'h0000)) begin
      next_pulse = (new_hi != 16'h0000);
    end else if (unit_tick && hi_cnt == 16'h0001) begin
      next_pulse = 1'b0;
    end
  end

  // reload at every period start, never stop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_cnt  <= `RST_COUNT;
      per_cnt <= `RST_COUNT;
      pre_cnt <= 8'h00;
      cur_m   <= 8'h00;
    end else if (begin_period || (unit_tick && per_cnt == 16'h0000)) begin
      hi_cnt  <= new_hi;
      per_cnt <= period_last;
      cur_m   <= pwm_reload[7:0];
      pre_cnt <= pwm_reload[7:0];
    end else if (pwm_tick) begin
      pre_cnt <= (pre_cnt == 8'h00) ? cur_m : pre_cnt - 8'h01;
      if (unit_tick) begin
        per_cnt <= per_cnt - 16'h0001;
        if (hi_cnt != 16'h0000) begin
          hi_cnt <= hi_cnt - 16'h0001;
        end
      end
    end else if (wr_pwm && !pwm_run) begin
      // stopped write loads the counter too
      hi_cnt <= merge16(pwm_reload, wb_dat_i, wb_sel_i);
    end
  end

  // reload register always takes the write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_reload <= `RST_COUNT;
    end else if (wr_pwm) begin
      pwm_reload <= merge16(pwm_reload, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_pulse_pin_o <= 1'b0;
      pwm_irq_o       <= 1'b0;
    end else begin
      pwm_pulse_pin_o <= next_pulse;
      pwm_irq_o       <= pwm_pulse_pin_o & ~next_pulse;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_pwm_wr_idle;
    wr_pwm && !pwm_run && next_state != PWM_RUN && wb_sel_i == 4'hF;
  endsequence

  sequence s_tmr0_under;
    tmr_under[0] && !(wr && wb_adr_i == `OFS_TMR_COUNT0);
  endsequence

  property p_stop_low;
    @(posedge clk_i) disable iff (rst_i) !pwm_run |-> !pwm_pulse_pin_o;
  endproperty
  a_stop_low: assert property (p_stop_low) else $error("pulse high while stopped");

  property p_irq_fall;
    @(posedge clk_i) disable iff (rst_i) $fell(pwm_pulse_pin_o) |-> pwm_irq_o;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("no irq on pulse fall");

  property p_irq_cause;
    @(posedge clk_i) disable iff (rst_i) pwm_irq_o |-> $fell(pwm_pulse_pin_o);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without pulse fall");

  // trigger leaves a running period alone
  property p_trig_ignored;
    @(posedge clk_i) disable iff (rst_i)
      pwm_run && trig_evt && pwm_start && per_cnt != 16'h0000 |=>
        per_cnt == $past(per_cnt) - 16'($past(unit_tick));
  endproperty
  a_trig_ignored: assert property (p_trig_ignored) else $error("trigger disturbed pwm");

  property p_wr_idle;
    @(posedge clk_i) disable iff (rst_i) s_pwm_wr_idle |=> hi_cnt == $past(wb_dat_i[15:0]);
  endproperty
  a_wr_idle: assert property (p_wr_idle) else $error("stopped write missed counter");

  property p_read_undef;
    @(posedge clk_i) disable iff (rst_i)
      req && !wb_we_i && wb_adr_i == `OFS_PWM_COUNT |=> wb_ack_o && wb_dat_o == `PWM_COUNT_READ;
  endproperty
  a_read_undef: assert property (p_read_undef) else $error("pwm count read not masked");

  property p_tmr_reload;
    @(posedge clk_i) disable iff (rst_i) s_tmr0_under |=> tmr_cnt[0] == $past(tmr_reload[0]);
  endproperty
  a_tmr_reload: assert property (p_tmr_reload) else $error("timer failed to reload");

  property p_tmr_halt;
    @(posedge clk_i) disable iff (rst_i)
      !tmr_start[1] && !wr |=> tmr_cnt[1] == $past(tmr_cnt[1]);
  endproperty
  a_tmr_halt: assert property (p_tmr_halt) else $error("halted timer counted");

  // 8-bit high count stays within a byte
  property p_hi8;
    @(posedge clk_i) disable iff (rst_i) pwm_run && eight_bit |-> hi_cnt[15:8] == 8'h00;
  endproperty
  a_hi8: assert property (p_hi8) else $error("8-bit high count overflowed");

  property p_period;
    @(posedge clk_i) disable iff (rst_i) per_cnt <= `PERIOD16_LAST;
  endproperty
  a_period: assert property (p_period) else $error("period counter out of range");

endmodule : pwm_timer

/* tb/pwm_load_model.sv */
`timescale 1ns/1ps
module pwm_load_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        pulse_i,
  input  wire logic        irq_i,
  input  wire logic        fire_i,
  input  wire logic [7:0]  delay_i,
  output logic             trig_o,
  output logic [31:0]      high_len_o,
  output logic [31:0]      period_o,
  output logic [31:0]      rises_o,
  output logic [31:0]      falls_o,
  output logic [31:0]      irq_hits_o
);
  logic        prev;
  logic [31:0] hi_cnt;
  logic [31:0] since;
  logic [8:0]  tcnt;

  ////////////////////////////////////////////////////////////////
  // trigger source: after the delay, three cycles high on the pin
  // trigger input
  always_ff @(posedge clk_i) begin
    if (rst_i)
      tcnt <= 9'h000;
    else if (fire_i)
      tcnt <= {1'b0, delay_i} + 9'h003;
    else if (tcnt != 9'h000)
      tcnt <= tcnt - 9'h001;
  end
  assign trig_o = (tcnt != 9'h000) && (tcnt <= 9'h003);

  ////////////////////////////////////////////////////////////////
  // load: period at each rise, high time and interrupt alignment at each fall
  always_ff @(posedge clk_i) begin
    prev <= pulse_i;
    if (rst_i) begin
      hi_cnt     <= 32'h0;
      since      <= 32'h0;
      high_len_o <= 32'h0;
      period_o   <= 32'h0;
      rises_o    <= 32'h0;
      falls_o    <= 32'h0;
      irq_hits_o <= 32'h0;
    end else begin
      since <= since + 32'h1;
      if (pulse_i)
        hi_cnt <= hi_cnt + 32'h1;
      if (pulse_i && !prev) begin
        rises_o  <= rises_o + 32'h1;
        period_o <= since;
        since    <= 32'h1;
        hi_cnt   <= 32'h1;
      end
      if (!pulse_i && prev) begin
        falls_o    <= falls_o + 32'h1;
        high_len_o <= hi_cnt;
        if (irq_i)
          irq_hits_o <= irq_hits_o + 32'h1;
      end
    end
  end
endmodule : pwm_load_model

/* tb/pwm_timer_with_prescaler_timers_tb_top.sv */
`timescale 1ns/1ps
`include "pwm_timer_map.svh"
module pwm_timer_with_prescaler_timers_tb_top;
  import pwm_timer_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  wb_adr_t     adr = 8'h00;
  wb_dat_t     wdat = 32'h0;
  logic        fire = 1'b0;
  logic        ack;
  wb_dat_t     rdat;
  wb_dat_t     q;
  logic        trig;
  logic        pulse;
  logic        pirq;
  logic [1:0]  tirq;
  logic [31:0] high_len;
  logic [31:0] period;
  logic [31:0] rises;
  logic [31:0] falls;
  logic [31:0] irq_hits;
  int          error_cnt = 0;
  int          check_count = 0;
  int          cycles = 0;

  // free-running clock
  always #10 clk = ~clk;

  pwm_timer u_pwm_timer (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_ack_o(ack),
    .wb_dat_o(rdat), .pwm_trigger_pin_i(trig), .pwm_pulse_pin_o(pulse),
    .pwm_irq_o(pirq), .timer_irq_o(tirq));

  pwm_load_model u_pwm_load_model (.clk_i(clk), .rst_i(rst), .pulse_i(pulse),
    .irq_i(pirq), .fire_i(fire), .delay_i(8'h05), .trig_o(trig), .high_len_o(high_len),
    .period_o(period), .rises_o(rises), .falls_o(falls), .irq_hits_o(irq_hits));

  ////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      error_cnt = error_cnt + 1;
      end_sim();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  // one classic bus cycle, held until ack is sampled
  task automatic wb(input logic w, input wb_adr_t a, input wb_dat_t d);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n >= 50)
      chk("ack", 32'h0, 32'h1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic wait_ev(input bit on_fall, input int k, input int lim);
    int base;
    int n;
    base = on_fall ? falls : rises;
    n = 0;
    while ((on_fall ? falls : rises) < base + k && n < lim) begin
      n++;
      @(posedge clk);
    end
  endtask : wait_ev

  task automatic irq_gap(input int i, output int g);
    int n;
    n = 0;
    while (tirq[i] !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
    end
    g = 1;
    @(posedge clk);
    while (tirq[i] !== 1'b1 && g < 100) begin
      g++;
      @(posedge clk);
    end
  endtask : irq_gap

  task automatic pwm_stop;
    int r;
    wb(1'b1, `OFS_START, 32'h0);
    repeat (2) @(posedge clk);
    chk("pulse stopped", 32'(pulse), 32'h0);
    r = rises;
    repeat (600) @(posedge clk);
    chk("stays stopped", rises, r);
  endtask : pwm_stop

  task automatic fire_trig;
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask : fire_trig

  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    wb(1'b0, `OFS_STATUS, 32'h0);
    chk("status", q, 32'h0);
    wb(1'b0, `OFS_TMR_COUNT0, 32'h0);
    chk("tmr0 count", q, 32'h0);
    wb(1'b0, 8'h3C, 32'h0);
    chk("unmapped", q, `UNMAPPED_READ);
    $display("reset test done");
  endtask : t_reset

  task automatic t_timer;
    int g;
    wb(1'b1, `OFS_TMR_MODE0, 32'h0);
    wb(1'b1, `OFS_TMR_MODE0 + 8'h04, 32'h0);
    wb(1'b1, `OFS_TMR_COUNT0, 32'h3);
    wb(1'b1, `OFS_TMR_COUNT0 + 8'h04, 32'h1);
    wb(1'b0, `OFS_TMR_COUNT0, 32'h0);
    chk("tmr0 load", q, 32'h3);
    wb(1'b1, `OFS_START, 32'h6);
    irq_gap(0, g);
    chk("tmr0 gap", g, 4);
    irq_gap(1, g);
    chk("tmr1 gap", g, 2);
    wb(1'b1, `OFS_TMR_COUNT0, 32'h7);
    wb(1'b0, `OFS_TMR_COUNT0, 32'h0);
    chk("tmr0 live", 32'(q <= 32'h3), 32'h1);
    irq_gap(0, g);
    irq_gap(0, g);
    chk("tmr0 new gap", g, 8);
    wb(1'b1, `OFS_START, 32'h0);
    wb(1'b0, `OFS_TMR_COUNT0, 32'h0);
    g = q;
    wb(1'b0, `OFS_TMR_COUNT0, 32'h0);
    chk("tmr0 halted", q, g);
    $display("timer test done");
  endtask : t_timer

  task automatic t_pwm8;
    wb(1'b1, `OFS_PWM_MODE, 32'h07);
    wb(1'b1, `OFS_PWM_COUNT, 32'h0201);
    wb(1'b0, `OFS_PWM_COUNT, 32'h0);
    chk("pwm read", q, `PWM_COUNT_READ);
    wb(1'b1, `OFS_START, 32'h1);
    wait_ev(1'b0, 3, 2000);
    chk("pwm8 high", high_len, 4);
    chk("pwm8 period", period, 510);
    wb(1'b1, `OFS_PWM_COUNT, 32'h0301);
    wait_ev(1'b0, 2, 2000);
    chk("pwm8 new high", high_len, 6);
    chk("pwm irq", irq_hits, falls);
    pwm_stop();
    $display("pwm8 test done");
  endtask : t_pwm8

  task automatic t_clk;
    logic [7:0] mode[2];
    int         mul[2];
    mode = '{8'h0F, 8'h17};
    mul  = '{8, 32};
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, `OFS_PWM_MODE, {24'h0, mode[i]});
      wb(1'b1, `OFS_PWM_COUNT, 32'h0100);
      wb(1'b1, `OFS_START, 32'h1);
      wait_ev(1'b0, 2, 9000);
      chk("div period", 32'(period > 254 * mul[i] && period <= 255 * mul[i]), 32'h1);
      wait_ev(1'b1, 1, 100);
      chk("div high", high_len, mul[i]);
      pwm_stop();
    end
    $display("clock test done");
  endtask : t_clk

  task automatic t_trig;
    int r;
    wb(1'b1, `OFS_PWM_MODE, 32'h27);
    wb(1'b1, `OFS_PWM_COUNT, 32'h0200);
    wb(1'b1, `OFS_START, 32'h1);
    r = rises;
    repeat (20) @(posedge clk);
    chk("armed idle", rises, r);
    fire_trig();
    wait_ev(1'b0, 1, 50);
    chk("pin start", rises, r + 1);
    repeat (100) @(posedge clk);
    fire_trig();
    wait_ev(1'b0, 1, 400);
    chk("retrigger ignored", period, 255);
    pwm_stop();
    wb(1'b1, `OFS_PWM_MODE, 32'h47);
    wb(1'b1, `OFS_START, 32'h3);
    r = rises;
    wait_ev(1'b0, 1, 50);
    chk("timer start", rises, r + 1);
    pwm_stop();
    $display("trigger test done");
  endtask : t_trig

  task automatic t_pwm16;
    wb(1'b1, `OFS_PWM_MODE, 32'h03);
    wb(1'b1, `OFS_PWM_COUNT, 32'h0005);
    wb(1'b1, `OFS_START, 32'h1);
    wait_ev(1'b0, 2, 70000);
    chk("pwm16 high", high_len, 5);
    chk("pwm16 period", period, 65535);
    pwm_stop();
    $display("pwm16 test done");
  endtask : t_pwm16

  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_timer();
    t_pwm8();
    t_clk();
    t_trig();
    t_pwm16();
    end_sim();
  end
endmodule : pwm_timer_with_prescaler_timers_tb_top
